// >>> hw/twmr_master_rx.sv
// Purpose: Byte-level two-wire bus master, receiver and address/transmit path
// Assumes: Bus pins open drain, sampled through two flip-flops
// Notes:   Software steps every byte through the step done flag
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns

// Function
// - Start waits for a free bus, then flag set with code 0x08.
// - Address direction bit selects transmit or receive operation.
// - After read address and acknowledge, flag set with 0x38, 0x40 or 0x48.
// - Lost in read address or NACK: release bus or restart when free.
// - Lost in write address or data: same release or restart choice.
// - Next byte received; ACK if acknowledge enable set, else NACK.
// - After NACK codes: repeated start, self-clearing stop, or both.
// - Received byte readable in data register while flag is set.
// - After 0x10 any slave may be addressed; write address transmits.
// - Status prescaler bits read as zero for code comparison.
// - Data write while flag low is discarded and sets write collision.
module twmr_master_rx (
  input  logic       core_clk,   // Core clock
  input  logic       reset_n,    // Async reset
  input  logic [1:0] regAddr,    // Register address
  input  logic [7:0] regWrData,  // Write data
  input  logic       regWr,      // Write strobe
  input  logic       regRd,      // Read strobe
  output logic [7:0] regRdData,  // Read data
  input  logic       sclIn,      // Clock line level
  output logic       sclOut,     // Clock line drive value
  output logic       sclOe,      // Clock line pull low
  input  logic       sdaIn,      // Data line level
  output logic       sdaOut,     // Data line drive value
  output logic       sdaOe       // Data line pull low
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  twmr_pkg::twmr_state_t state_r;
  logic [1:0] phase_r;
  logic [7:0] qCnt_r;
  logic [3:0] bitCnt_r;
  logic       sclOe_r;
  logic       sdaOe_r;
  logic [7:0] status_r;
  logic       flagSet_r;
  logic       stopDone_r;
  logic       rxMode_r;
  logic       nextIsAddr_r;
  logic       lost_r;
  logic       flag_r;
  logic       en_r;
  logic       sta_r;
  logic       sto_r;
  logic       ackEn_r;
  logic       wcol_r;
  logic [7:0] dataReg_r;
  logic [7:0] regRdData_r;
  logic       sclMeta_r;
  logic       sclS_r;
  logic       sdaMeta_r;
  logic       sdaS_r;
  logic       sdaPrev_r;
  logic       busy_r;
  logic       ctrlWr;
  logic       dataWr;
  logic       go;
  logic       qDone;
  logic       tx;
  logic       bitDrive;
  logic       arbLoss;
  logic       shiftTick;
  logic       stretch;
  logic [7:0] byteCode;

  assign sclOut    = 1'b0;
  assign sdaOut    = 1'b0;
  assign sclOe     = sclOe_r;
  assign sdaOe     = sdaOe_r;
  assign regRdData = regRdData_r;

  // ---------------------------------------------------------------
  // Pin synchronisers and bus busy tracking
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclMeta_r <= 1'b1;
      sclS_r    <= 1'b1;
      sdaMeta_r <= 1'b1;
      sdaS_r    <= 1'b1;
      sdaPrev_r <= 1'b1;
    end else begin
      sclMeta_r <= sclIn;
      sclS_r    <= sclMeta_r;
      sdaMeta_r <= sdaIn;
      sdaS_r    <= sdaMeta_r;
      sdaPrev_r <= sdaS_r;
    end
  end

  // Start condition marks busy, stop condition frees
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
    end else if (sclS_r && sdaPrev_r && !sdaS_r) begin
      busy_r <= 1'b1;
    end else if (sclS_r && !sdaPrev_r && sdaS_r) begin
      busy_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Decode and bit helpers
  // ---------------------------------------------------------------
  assign ctrlWr    = regWr && (regAddr == twmr_pkg::CTRL_OFS);
  assign dataWr    = regWr && (regAddr == twmr_pkg::DATA_OFS);
  assign go        = ctrlWr && regWrData[twmr_pkg::FLAG_BIT] && flag_r;
  assign qDone     = (qCnt_r == 8'h00);
  assign tx        = nextIsAddr_r || !rxMode_r;
  assign stretch   = (phase_r == 2'h2) && !sclS_r;
  assign shiftTick = (state_r == twmr_pkg::ST_XFER) && (phase_r == 2'h3) && qDone
                     && (bitCnt_r < twmr_pkg::ACK_BIT_IDX);

  always_comb begin
    if (bitCnt_r < twmr_pkg::ACK_BIT_IDX) begin
      bitDrive = tx && !dataReg_r[7];
    end else begin
      bitDrive = !tx && ackEn_r;
    end
  end

  // Released line read low where we expected high
  always_comb begin
    if (bitCnt_r < twmr_pkg::ACK_BIT_IDX) begin
      arbLoss = !sdaOe_r && !sdaS_r && tx;
    end else begin
      arbLoss = !sdaOe_r && !sdaS_r && !tx;
    end
  end

  always_comb begin
    if (nextIsAddr_r && dataReg_r[0]) begin
      byteCode = sdaS_r ? twmr_pkg::STAT_AR_NACK : twmr_pkg::STAT_AR_ACK;
    end else if (nextIsAddr_r) begin
      byteCode = sdaS_r ? twmr_pkg::STAT_AW_NACK : twmr_pkg::STAT_AW_ACK;
    end else if (rxMode_r) begin
      byteCode = sdaOe_r ? twmr_pkg::STAT_DR_ACK : twmr_pkg::STAT_DR_NACK;
    end else begin
      byteCode = sdaS_r ? twmr_pkg::STAT_DW_NACK : twmr_pkg::STAT_DW_ACK;
    end
  end

  // ---------------------------------------------------------------
  // Bus engine
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r      <= twmr_pkg::ST_IDLE;
      phase_r      <= 2'h0;
      qCnt_r       <= 8'h00;
      bitCnt_r     <= 4'h0;
      sclOe_r      <= 1'b0;
      sdaOe_r      <= 1'b0;
      status_r     <= twmr_pkg::STAT_NONE;
      flagSet_r    <= 1'b0;
      stopDone_r   <= 1'b0;
      rxMode_r     <= 1'b0;
      nextIsAddr_r <= 1'b0;
      lost_r       <= 1'b0;
    end else begin
      flagSet_r  <= 1'b0;
      stopDone_r <= 1'b0;
      qCnt_r     <= qDone ? twmr_pkg::Q_RELOAD : qCnt_r - 8'h01;
      if (!en_r) begin
        state_r <= twmr_pkg::ST_IDLE;
        sclOe_r <= 1'b0;
        sdaOe_r <= 1'b0;
      end else begin
        case (state_r)
          twmr_pkg::ST_IDLE: begin
            sclOe_r <= 1'b0;
            sdaOe_r <= 1'b0;
            if (sta_r && !flag_r) begin
              state_r <= twmr_pkg::ST_WAITFREE;
            end
          end
          twmr_pkg::ST_WAITFREE: begin
            if (!busy_r) begin
              state_r <= twmr_pkg::ST_START;
              phase_r <= 2'h0;
              qCnt_r  <= twmr_pkg::Q_RELOAD;
            end
          end
          twmr_pkg::ST_START: begin
            sdaOe_r <= 1'b1;
            if (qDone) begin
              phase_r <= phase_r + 2'h1;
              if (phase_r == 2'h1) begin
                sclOe_r      <= 1'b1;
                state_r      <= twmr_pkg::ST_HOLD;
                status_r     <= twmr_pkg::STAT_START;
                flagSet_r    <= 1'b1;
                nextIsAddr_r <= 1'b1;
                lost_r       <= 1'b0;
              end
            end
          end
          twmr_pkg::ST_HOLD: begin
            if (go) begin
              phase_r  <= 2'h0;
              qCnt_r   <= twmr_pkg::Q_RELOAD;
              bitCnt_r <= 4'h0;
              if (lost_r) begin
                state_r <= regWrData[twmr_pkg::START_BIT] ? twmr_pkg::ST_WAITFREE
                                                           : twmr_pkg::ST_IDLE;
              end else if (regWrData[twmr_pkg::STOP_BIT]) begin
                state_r <= twmr_pkg::ST_STOP;
              end else if (regWrData[twmr_pkg::START_BIT]) begin
                state_r <= twmr_pkg::ST_RESTART;
              end else begin
                state_r <= twmr_pkg::ST_XFER;
              end
            end
          end
          twmr_pkg::ST_XFER, twmr_pkg::ST_RESTART, twmr_pkg::ST_STOP: begin
            if (phase_r == 2'h0) begin
              if (state_r == twmr_pkg::ST_XFER) begin
                sdaOe_r <= bitDrive;
              end else begin
                sdaOe_r <= (state_r == twmr_pkg::ST_STOP);
              end
            end
            if (stretch) begin
              qCnt_r <= twmr_pkg::Q_RELOAD;
            end else if (qDone) begin
              phase_r <= phase_r + 2'h1;
              if (phase_r == 2'h1) begin
                sclOe_r <= 1'b0;
              end
              if (phase_r == 2'h2 && state_r != twmr_pkg::ST_XFER) begin
                sdaOe_r <= (state_r == twmr_pkg::ST_RESTART);
              end
              if (phase_r == 2'h3) begin
                sclOe_r  <= 1'b1;
                bitCnt_r <= bitCnt_r + 4'h1;
                if (state_r == twmr_pkg::ST_STOP) begin
                  sclOe_r    <= 1'b0;
                  stopDone_r <= 1'b1;
                  state_r    <= sta_r ? twmr_pkg::ST_WAITFREE : twmr_pkg::ST_IDLE;
                end else if (state_r == twmr_pkg::ST_RESTART) begin
                  state_r      <= twmr_pkg::ST_HOLD;
                  status_r     <= twmr_pkg::STAT_RESTART;
                  flagSet_r    <= 1'b1;
                  nextIsAddr_r <= 1'b1;
                end else if (arbLoss) begin
                  sclOe_r   <= 1'b0;
                  sdaOe_r   <= 1'b0;
                  lost_r    <= 1'b1;
                  state_r   <= twmr_pkg::ST_HOLD;
                  status_r  <= twmr_pkg::STAT_LOST;
                  flagSet_r <= 1'b1;
                end else if (bitCnt_r == twmr_pkg::ACK_BIT_IDX) begin
                  state_r      <= twmr_pkg::ST_HOLD;
                  status_r     <= byteCode;
                  flagSet_r    <= 1'b1;
                  nextIsAddr_r <= 1'b0;
                  if (nextIsAddr_r) begin
                    rxMode_r <= dataReg_r[0];
                  end
                end
              end
            end
          end
          default: begin
            state_r <= twmr_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Control register and step done flag
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      en_r    <= twmr_pkg::CTRL_RESET[twmr_pkg::EN_BIT];
      sta_r   <= twmr_pkg::CTRL_RESET[twmr_pkg::START_BIT];
      sto_r   <= twmr_pkg::CTRL_RESET[twmr_pkg::STOP_BIT];
      ackEn_r <= twmr_pkg::CTRL_RESET[twmr_pkg::ACKEN_BIT];
    end else begin
      if (ctrlWr) begin
        en_r    <= regWrData[twmr_pkg::EN_BIT];
        sta_r   <= regWrData[twmr_pkg::START_BIT];
        sto_r   <= regWrData[twmr_pkg::STOP_BIT];
        ackEn_r <= regWrData[twmr_pkg::ACKEN_BIT];
      end
      if (stopDone_r) begin
        sto_r <= 1'b0;
      end
    end
  end

  // Hardware set wins over a clearing write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= twmr_pkg::CTRL_RESET[twmr_pkg::FLAG_BIT];
    end else if (flagSet_r) begin
      flag_r <= 1'b1;
    end else if (ctrlWr && regWrData[twmr_pkg::FLAG_BIT]) begin
      flag_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Data register and write collision
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dataReg_r <= twmr_pkg::DATA_RESET;
      wcol_r    <= 1'b0;
    end else if (dataWr) begin
      if (flag_r) begin
        dataReg_r <= regWrData;
        wcol_r    <= 1'b0;
      end else begin
        wcol_r <= 1'b1;
      end
    end else if (shiftTick) begin
      dataReg_r <= {dataReg_r[6:0], sdaS_r};
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData_r <= 8'h00;
    end else if (!regRd) begin
      regRdData_r <= 8'h00;
    end else begin
      case (regAddr)
        twmr_pkg::CTRL_OFS: regRdData_r <= {flag_r, ackEn_r, sta_r, sto_r, wcol_r, en_r, 2'h0};
        twmr_pkg::STAT_OFS: regRdData_r <= {status_r[7:2], 2'h0};
        twmr_pkg::DATA_OFS: regRdData_r <= dataReg_r;
        default:            regRdData_r <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_START_FREE: assert property (
    $past(state_r) == twmr_pkg::ST_WAITFREE && state_r == twmr_pkg::ST_START |-> !$past(busy_r))
    else $error("Start begun on a busy bus");
  AST_START_CODE: assert property (
    $past(state_r) == twmr_pkg::ST_START && state_r == twmr_pkg::ST_HOLD
    |-> status_r == 8'h08 ##1 flag_r)
    else $error("Start not reported as 0x08");
  AST_DIR_MODE: assert property (
    $fell(nextIsAddr_r) && !lost_r |-> rxMode_r == dataReg_r[0])
    else $error("Mode does not follow address direction");
  AST_ADDR_CODE: assert property (
    $fell(nextIsAddr_r) && rxMode_r
    |-> status_r inside {8'h38, 8'h40, 8'h48} ##1 flag_r)
    else $error("Bad code after read address");
  AST_LOST_RELEASE: assert property (
    lost_r && state_r == twmr_pkg::ST_HOLD |-> !sclOe_r && !sdaOe_r)
    else $error("Bus not released after lost arbitration");
  AST_ACK_DRIVE: assert property (
    state_r == twmr_pkg::ST_XFER && !tx && bitCnt_r == 4'h8 && phase_r == 2'h2
    |-> sdaOe_r == ackEn_r)
    else $error("Acknowledge does not follow enable");
  AST_STOP_CLEAR: assert property (
    stopDone_r |=> !sto_r && !sdaOe_r && !sclOe_r)
    else $error("Stop request not cleared after stop");
  AST_DATA_STEADY: assert property (
    flag_r && $past(flag_r) && !$past(dataWr) |-> $stable(dataReg_r))
    else $error("Data changed while flag set");
  AST_RESTART_CODE: assert property (
    $past(state_r) == twmr_pkg::ST_RESTART && state_r == twmr_pkg::ST_HOLD
    |-> status_r == 8'h10 && nextIsAddr_r)
    else $error("Repeated start not reported as 0x10");
  AST_PRESCALE_ZERO: assert property (
    $past(regRd) && $past(regAddr) == twmr_pkg::STAT_OFS |-> regRdData_r[1:0] == 2'h0)
    else $error("Status low bits not zero");
  AST_WCOL: assert property (
    dataWr && !flag_r |=> wcol_r && ($stable(dataReg_r) || $past(shiftTick)))
    else $error("Collision write not flagged");
  AST_STRETCH: assert property (
    flag_r && !lost_r && en_r && state_r == twmr_pkg::ST_HOLD |-> sclOe_r)
    else $error("Clock released while flag set");
endmodule // twmr_master_rx

// >>> inc/twmr_pkg.sv
// Purpose: Shared constants and types of the two-wire master receiver
// Assumes: 8-bit register port, 10 MHz core clock
// Notes:   Status codes carry zero in the two prescaler bits
package twmr_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [1:0] CTRL_OFS = 2'h0;
  localparam logic [1:0] STAT_OFS = 2'h1;
  localparam logic [1:0] DATA_OFS = 2'h2;
  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int FLAG_BIT  = 7;
  localparam int ACKEN_BIT = 6;
  localparam int START_BIT = 5;
  localparam int STOP_BIT  = 4;
  localparam int WCOL_BIT  = 3;
  localparam int EN_BIT    = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'hFF;
  // ---------------------------------------------------------------
  // Status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] STAT_START   = 8'h08;
  localparam logic [7:0] STAT_RESTART = 8'h10;
  localparam logic [7:0] STAT_AW_ACK  = 8'h18;
  localparam logic [7:0] STAT_AW_NACK = 8'h20;
  localparam logic [7:0] STAT_DW_ACK  = 8'h28;
  localparam logic [7:0] STAT_DW_NACK = 8'h30;
  localparam logic [7:0] STAT_LOST    = 8'h38;
  localparam logic [7:0] STAT_AR_ACK  = 8'h40;
  localparam logic [7:0] STAT_AR_NACK = 8'h48;
  localparam logic [7:0] STAT_DR_ACK  = 8'h50;
  localparam logic [7:0] STAT_DR_NACK = 8'h58;
  localparam logic [7:0] STAT_NONE    = 8'hF8;
  // ---------------------------------------------------------------
  // Bus timing
  // ---------------------------------------------------------------
  localparam int CLK_NS      = 100;
  localparam int QUARTER_NS  = 2500;
  localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] Q_RELOAD = 8'(QUARTER_CYC - 1);
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;
  // ---------------------------------------------------------------
  // Engine states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_WAITFREE = 3'b001,
    ST_START    = 3'b010,
    ST_XFER     = 3'b011,
    ST_HOLD     = 3'b100,
    ST_RESTART  = 3'b101,
    ST_STOP     = 3'b110
  } twmr_state_t;
endpackage

// >>> tb/tb_twmr_master_rx.sv
// Purpose: Self-checking bench of the two-wire master receiver
// Assumes: Open-drain lines pulled up, slave model on the far side
// Notes:   Random byte counts and addresses from a fixed seed
`timescale 1ns/1ns
module tb_twmr_master_rx;
  localparam logic [6:0] SLV_ADDR  = 7'h52;
  localparam logic [7:0] BYTE_BASE = 8'hA5;
  localparam logic [7:0] BYTE_STEP = 8'h13;
  logic       core_clk, reset_n, regWr, regRd, sclOe, sdaOe, slvSclOe, slvSdaOe, slow, rogueLow;
  logic [1:0] regAddr;
  logic [7:0] regWrData, regRdData, rdVal;
  logic [6:0] badAddr;
  wire logic  sclLine, sdaLine;
  int         n_mismatch, samples_checked, seed, nBytes;
  assign sclLine = ~(sclOe | slvSclOe);
  assign sdaLine = ~(sdaOe | slvSdaOe | rogueLow);
  twmr_master_rx dut (.core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sclIn(sclLine), .sclOut(), .sclOe(sclOe),
    .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe));
  twmr_slave_model #(.SLV_ADDR(SLV_ADDR), .BYTE_BASE(BYTE_BASE), .BYTE_STEP(BYTE_STEP)) slave (
    .scl(sclLine), .sda(sdaLine), .slow(slow), .sclOe(slvSclOe), .sdaOe(slvSdaOe));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] slvByte(input int k);
    return BYTE_BASE + 8'(k) * BYTE_STEP;
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [1:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    d = regRdData;
  endtask
  task automatic rdChk(input string what, input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] v;
    regRead(a, v);
    chk(what, exp, v);
  endtask
  task automatic waitFlag(input logic [7:0] code);
    logic [7:0] v;
    int k;
    v = 8'h00;
    k = 0;
    while (v[7] !== 1'b1 && k < 40) begin
      repeat (100) @(posedge core_clk);
      regRead(twmr_pkg::CTRL_OFS, v);
      k++;
    end
    chk("flag", 8'h80, v & 8'h80);
    rdChk("status", twmr_pkg::STAT_OFS, code);
    chk("clock hold", {7'h00, code != twmr_pkg::STAT_LOST}, {7'h00, sclOe});
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    seed = 45001;
    n_mismatch = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 2'h0;
    regWrData = 8'h00;
    slow = 1'b0;
    rogueLow = 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    rdChk("ctrl reset", twmr_pkg::CTRL_OFS, twmr_pkg::CTRL_RESET);
    rdChk("status reset", twmr_pkg::STAT_OFS, twmr_pkg::STAT_NONE);
    rdChk("data reset", twmr_pkg::DATA_OFS, twmr_pkg::DATA_RESET);
    regWrite(2'h3, 8'h5A);
    rdChk("unmapped", 2'h3, 8'h00);
    regWrite(twmr_pkg::DATA_OFS, 8'($random(seed)));
    rdChk("collision", twmr_pkg::CTRL_OFS, 8'h08);
    rdChk("data kept", twmr_pkg::DATA_OFS, twmr_pkg::DATA_RESET);
    for (int pass = 0; pass < 2; pass++) begin
      slow <= 1'(pass);
      nBytes = 1 + ($unsigned($random(seed)) % 3);
      badAddr = 7'($random(seed));
      if (badAddr == SLV_ADDR)
        badAddr = badAddr ^ 7'h01;
      regWrite(twmr_pkg::CTRL_OFS, 8'hA4);
      waitFlag(twmr_pkg::STAT_START);
      regWrite(twmr_pkg::DATA_OFS, {SLV_ADDR, 1'b1});
      regRead(twmr_pkg::CTRL_OFS, rdVal);
      chk("collision clear", 8'h00, rdVal & 8'h08);
      regWrite(twmr_pkg::CTRL_OFS, 8'hC4);
      waitFlag(twmr_pkg::STAT_AR_ACK);
      for (int k = 0; k < nBytes; k++) begin
        regWrite(twmr_pkg::CTRL_OFS, (k == nBytes - 1) ? 8'h84 : 8'hC4);
        waitFlag((k == nBytes - 1) ? twmr_pkg::STAT_DR_NACK : twmr_pkg::STAT_DR_ACK);
        rdChk("rx byte", twmr_pkg::DATA_OFS, slvByte(k));
      end
      regWrite(twmr_pkg::CTRL_OFS, 8'hB4);
      waitFlag(twmr_pkg::STAT_START);
      regWrite(twmr_pkg::DATA_OFS, {badAddr, 1'b1});
      regWrite(twmr_pkg::CTRL_OFS, 8'h84);
      waitFlag(twmr_pkg::STAT_AR_NACK);
      regWrite(twmr_pkg::CTRL_OFS, 8'hA4);
      waitFlag(twmr_pkg::STAT_RESTART);
      regWrite(twmr_pkg::DATA_OFS, {SLV_ADDR, 1'b0});
      regWrite(twmr_pkg::CTRL_OFS, 8'h84);
      waitFlag(twmr_pkg::STAT_AW_ACK);
      regWrite(twmr_pkg::DATA_OFS, 8'($random(seed)));
      regWrite(twmr_pkg::CTRL_OFS, 8'h84);
      waitFlag(twmr_pkg::STAT_DW_NACK);
      regWrite(twmr_pkg::CTRL_OFS, 8'h94);
      repeat (400) @(posedge core_clk);
      regRead(twmr_pkg::CTRL_OFS, rdVal);
      chk("stop clear", 8'h00, rdVal & 8'h90);
      chk("lines idle", 8'h03, {6'h00, sclLine, sdaLine});
    end
    for (int i = 0; i < 2; i++) begin
      regWrite(twmr_pkg::CTRL_OFS, 8'hA4);
      waitFlag(twmr_pkg::STAT_START);
      regWrite(twmr_pkg::DATA_OFS, (i == 1) ? 8'hFF : 8'hFE);
      rogueLow <= 1'b1;
      regWrite(twmr_pkg::CTRL_OFS, 8'h84);
      waitFlag(twmr_pkg::STAT_LOST);
      chk("data released", 8'h00, {7'h00, sdaOe});
      regWrite(twmr_pkg::CTRL_OFS, (i == 1) ? 8'hA4 : 8'h84);
      repeat (300) @(posedge core_clk);
      regRead(twmr_pkg::CTRL_OFS, rdVal);
      chk("no start while busy", 8'h00, rdVal & 8'h80);
      rogueLow <= 1'b0;
      if (i == 1) begin
        waitFlag(twmr_pkg::STAT_START);
        regWrite(twmr_pkg::CTRL_OFS, 8'h94);
      end
      repeat (400) @(posedge core_clk);
      @(negedge core_clk);
      chk("bus free", 8'h00, {6'h00, sclOe, sdaOe});
    end
    // Reset in mid-frame must drop both lines and the registers
    regWrite(twmr_pkg::CTRL_OFS, 8'hA4);
    waitFlag(twmr_pkg::STAT_START);
    reset_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    chk("reset lines", 8'h00, {6'h00, sclOe, sdaOe});
    rdChk("reset ctrl", twmr_pkg::CTRL_OFS, twmr_pkg::CTRL_RESET);
    rdChk("reset status", twmr_pkg::STAT_OFS, twmr_pkg::STAT_NONE);
    tally_and_finish();
  end
endmodule // tb_twmr_master_rx

// >>> tb/twmr_slave_model.sv
// Purpose: Behavioural slave transmitter on the two-wire bus
// Assumes: Lines resolved by the bench, pulled up when released
// Notes:   Byte k after an address match is BYTE_BASE + k * BYTE_STEP
`timescale 1ns/1ns
module twmr_slave_model #(
  parameter logic [6:0] SLV_ADDR  = 7'h52,
  parameter logic [7:0] BYTE_BASE = 8'hA5,
  parameter logic [7:0] BYTE_STEP = 8'h13
) (
  input  wire logic scl,   // Resolved clock line
  input  wire logic sda,   // Resolved data line
  input  wire logic slow,  // Stretch clock low
  output logic      sclOe, // Pull clock line low
  output logic      sdaOe  // Pull data line low
);
  logic [7:0] shiftIn;
  logic [7:0] txByte;
  logic       masterAck;
  logic       startSeen;
  initial begin
    sclOe = 1'b0;
    sdaOe = 1'b0;
    startSeen = 1'b0;
  end
  // ---------------------------------------------------------------
  // Start or stop aborts the frame
  // ---------------------------------------------------------------
  always @(sda) begin
    if (scl === 1'b1) begin
      disable frame;
      sdaOe = 1'b0;
      startSeen = ~sda;
    end
  end
  always begin : frame
    wait (startSeen);
    startSeen = 1'b0;
    repeat (8) begin
      @(posedge scl);
      shiftIn = {shiftIn[6:0], sda};
    end
    @(negedge scl);
    if (shiftIn[7:1] == SLV_ADDR) begin
      sdaOe = 1'b1;
      @(negedge scl);
      sdaOe = 1'b0;
      txByte = BYTE_BASE;
      masterAck = shiftIn[0];
      while (masterAck) begin
        for (int i = 7; i >= 0; i--) begin
          sdaOe = ~txByte[i];
          @(negedge scl);
        end
        sdaOe = 1'b0;
        @(posedge scl);
        masterAck = ~sda;
        @(negedge scl);
        txByte = txByte + BYTE_STEP;
      end
    end
  end
  // ---------------------------------------------------------------
  // Slow answers stretch the clock
  // ---------------------------------------------------------------
  always @(negedge scl) begin
    if (slow && !sclOe) begin
      sclOe = 1'b1;
      #7000;
      sclOe = 1'b0;
    end
  end
endmodule // twmr_slave_model
